//--- hw/scp_host.sv
`timescale 1ns/1ps
`include "scp_defines.svh"

// Overview of operation
// RULE1: Four-wire or three-wire shared data line wiring.
// RULE2: Every frame is exactly 24 counted bits.
// RULE3: First bit gives direction, read or write.
// RULE4: Fifteen address bits follow the direction bit.
// RULE5: Write frames end with the stored data byte.
// RULE6: Read frames: host drives first sixteen bits.
// RULE7: Device returns read byte in last eight.
// RULE8: Chip select low frames, MSB first, high reads.
module scp_host #(
  parameter int HALF = `SCP_HALF_CYCLES
) (
  scp_if.host                bus,
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          three_wire,
  input  wire logic          start,
  input  wire logic          read,
  input  scp_pkg::addr_type  addr,
  input  scp_pkg::data_type  wdata,
  output logic               busy,
  output logic               done,
  output scp_pkg::data_type  rdata
);
  import scp_pkg::*;

  // The phase counter is eight bits wide, so longer halves cannot be paced.
  if (HALF < `SCP_HALF_MIN || HALF > 255) begin : g_half_check
    $error("HALF must lie between 2 and 255 clock cycles");
  end

  function automatic logic half_over(input logic [7:0] ph);
    half_over = ph == 8'(HALF - 1);
  endfunction

  host_state_type state;
  host_state_type next_state;
  logic [7:0]     phase;
  bit_count_type  bit_idx;
  logic [23:0]    shift;
  logic           is_read;
  logic           mode;
  logic           sclk;
  logic           cs_n;
  logic           sdio_out;
  logic           sdio_oe;
  data_type       rx;
  logic           sdio_s1;
  logic           sdio_s2;
  logic           sdo_s1;
  logic           sdo_s2;
  logic           rx_bit;
  logic           tick;
  logic           last_bit;

  assign tick     = half_over(phase);
  assign last_bit = bit_idx == 5'(`SCP_FRAME_BITS - 1);
  assign rx_bit   = mode ? sdio_s2 : sdo_s2; // RULE1

  // Data pins come from the device and are synchronised first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdio_s1 <= `SCP_LINE_IDLE;
      sdio_s2 <= `SCP_LINE_IDLE;
      sdo_s1  <= `SCP_LINE_IDLE;
      sdo_s2  <= `SCP_LINE_IDLE;
    end else begin
      sdio_s1 <= bus.sdio;
      sdio_s2 <= sdio_s1;
      sdo_s1  <= bus.sdo_line;
      sdo_s2  <= sdo_s1;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (start) begin
          next_state = st_low;
        end
      end
      st_low: begin
        if (tick) begin
          next_state = st_high;
        end
      end
      st_high: begin
        if (tick) begin
          next_state = last_bit ? st_end : st_low;
        end
      end
      st_end: begin
        if (tick) begin
          next_state = st_gap;
        end
      end
      st_gap: begin
        if (tick) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // One counter paces every half period of the serial clock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (state == st_idle || tick) begin
      phase <= '0;
    end else begin
      phase <= phase + 8'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk <= `SCP_SCLK_IDLE;
    end else if (state == st_low && tick) begin
      sclk <= 1'b1;
    end else if (state == st_high && tick) begin
      sclk <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n <= `SCP_CS_IDLE;
    end else if (state == st_idle && start) begin
      cs_n <= 1'b0; // RULE8
    end else if (state == st_end && tick) begin
      cs_n <= 1'b1; // RULE8
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_idx <= '0;
    end else if (state == st_idle) begin
      bit_idx <= '0;
    end else if (state == st_high && tick && !last_bit) begin
      bit_idx <= bit_idx + 5'd1; // RULE2
    end
  end

  // The request and the wiring mode are held for the whole frame.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift   <= '0;
      is_read <= 1'b0;
      mode    <= 1'b0;
    end else if (state == st_idle && start) begin
      shift   <= {read ? `SCP_DIR_READ : `SCP_DIR_WRITE,
                  addr, wdata}; // RULE3
      is_read <= read;
      mode    <= three_wire; // RULE1
    end else if (state == st_high && tick) begin
      shift <= {shift[22:0], 1'b0}; // RULE4
    end
  end

  // New data bits change only while the serial clock is low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdio_out <= `SCP_LINE_IDLE;
    end else if (state == st_idle && start) begin
      sdio_out <= read; // RULE3
    end else if (state == st_high && tick && !last_bit) begin
      sdio_out <= shift[22]; // RULE5
    end else if (state == st_gap) begin
      sdio_out <= `SCP_LINE_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdio_oe <= 1'b0;
    end else if (state == st_idle && start) begin
      sdio_oe <= 1'b1;
    end else if (state == st_high && tick && is_read &&
                 bit_idx == 5'(`SCP_ADDR_LAST)) begin
      sdio_oe <= 1'b0; // RULE6
    end else if (state == st_end && tick) begin
      sdio_oe <= 1'b0;
    end
  end

  // Read bits are taken at the end of each high phase.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx <= `SCP_BYTE_RESET;
    end else if (state == st_high && tick && is_read &&
                 bit_idx >= 5'(`SCP_DATA_FIRST)) begin
      rx <= {rx[6:0], rx_bit}; // RULE7
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `SCP_BYTE_RESET;
    end else if (state == st_end && tick && is_read) begin
      rdata <= rx;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= state == st_end && tick;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= next_state != st_idle;
    end
  end

  assign bus.sclk          = sclk;
  assign bus.cs_n          = cs_n;
  assign bus.host_sdio_out = sdio_out;
  assign bus.host_sdio_oe  = sdio_oe;
endmodule

//--- inc/scp_defines.svh
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// Frame layout, most significant bit first on the wire.
`define SCP_FRAME_BITS   24
`define SCP_ADDR_BITS    15
`define SCP_DATA_BITS    8
`define SCP_DIR_POS      23
`define SCP_ADDR_POS     8
`define SCP_ADDR_LAST    15
`define SCP_DATA_FIRST   16
`define SCP_DATA_LAST    23

// Direction bit encoding.
`define SCP_DIR_READ     1'b1
`define SCP_DIR_WRITE    1'b0

// Reset values.
`define SCP_CS_IDLE      1'b1
`define SCP_SCLK_IDLE    1'b0
`define SCP_LINE_IDLE    1'b1
`define SCP_BYTE_RESET   8'h00

// Serial clock timing made by the host divider.
`define SCP_CLK_NS       10
`define SCP_HALF_NS      20
`define SCP_HALF_CYCLES  ((`SCP_HALF_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`define SCP_HALF_MIN     2

// Depth of the device register store, in address bits.
`define SCP_STORE_BITS   8

`endif

//--- inc/scp_pkg.sv
package scp_pkg;

  typedef logic [14:0] addr_type;
  typedef logic [7:0]  data_type;
  typedef logic [4:0]  bit_count_type;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_low  = 3'b001,
    st_high = 3'b010,
    st_end  = 3'b011,
    st_gap  = 3'b100
  } host_state_type;

endpackage

//--- inc/scp_if.sv
`timescale 1ns/1ps

interface scp_if;
  logic sclk;
  logic cs_n;
  logic host_sdio_out;
  logic host_sdio_oe;
  logic dev_sdio_out;
  logic dev_sdio_oe;
  logic serial_data_out;
  logic serial_data_out_oe;
  logic sdio;
  logic sdo_line;

  // Lines idle high through a pull-up when nobody drives them.
  assign sdio = host_sdio_oe ? host_sdio_out :
                dev_sdio_oe  ? dev_sdio_out  : 1'b1;
  assign sdo_line = serial_data_out_oe ? serial_data_out : 1'b1;

  modport host (
    output sclk,
    output cs_n,
    output host_sdio_out,
    output host_sdio_oe,
    input  sdio,
    input  sdo_line
  );

  modport dev (
    input  sclk,
    input  cs_n,
    input  sdio,
    output dev_sdio_out,
    output dev_sdio_oe,
    output serial_data_out,
    output serial_data_out_oe
  );
endinterface

//--- hw/scp_device.sv
`timescale 1ns/1ps
`include "scp_defines.svh"

module scp_device #(
  parameter int STORE_BITS = `SCP_STORE_BITS
) (
  scp_if.dev                 bus,
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          three_wire,
  output logic               wr_valid,
  output scp_pkg::addr_type  wr_addr,
  output scp_pkg::data_type  wr_data
);
  import scp_pkg::*;

  if (STORE_BITS < 1 || STORE_BITS > `SCP_ADDR_BITS) begin : g_store_check
    $error("STORE_BITS must lie between 1 and 15");
  end

  function automatic logic mapped(input addr_type a);
    mapped = (a >> STORE_BITS) == '0;
  endfunction

  data_type      store [0:(1 << STORE_BITS) - 1];
  bit_count_type bit_cnt;
  logic          dir;
  addr_type      addr;
  logic [6:0]    din;
  data_type      dout;
  logic          sdio_oe;
  logic          sdo_oe;
  logic          mode_s1;
  logic          mode_s2;
  logic          wr_tgl;
  addr_type      wr_addr_l;
  data_type      wr_data_l;
  logic          tgl_s1;
  logic          tgl_s2;
  logic          tgl_s3;
  logic          last_write;
  data_type      next_wr_byte;

  assign next_wr_byte = {din, bus.sdio};
  assign last_write = (dir == `SCP_DIR_WRITE) &&
                      (bit_cnt == 5'(`SCP_DATA_LAST));

  // The mode strap is a level from outside the link domain.
  always_ff @(posedge bus.sclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
    end else begin
      mode_s1 <= three_wire;
      mode_s2 <= mode_s1;
    end
  end

  // Chip select high clears the frame position at once.
  always_ff @(posedge bus.sclk or negedge rst_n or posedge bus.cs_n) begin
    if (!rst_n) begin
      bit_cnt <= '0;
    end else if (bus.cs_n) begin
      bit_cnt <= '0; // RULE8
    end else if (bit_cnt != 5'(`SCP_FRAME_BITS)) begin
      bit_cnt <= bit_cnt + 5'd1; // RULE2
    end
  end

  always_ff @(posedge bus.sclk or negedge rst_n) begin
    if (!rst_n) begin
      dir <= `SCP_DIR_WRITE;
    end else if (bit_cnt == 5'd0) begin
      dir <= bus.sdio; // RULE3
    end
  end

  always_ff @(posedge bus.sclk or negedge rst_n) begin
    if (!rst_n) begin
      addr <= '0;
    end else if (bit_cnt >= 5'd1 && bit_cnt <= 5'(`SCP_ADDR_LAST)) begin
      addr <= {addr[13:0], bus.sdio}; // RULE4
    end
  end

  always_ff @(posedge bus.sclk or negedge rst_n) begin
    if (!rst_n) begin
      din <= '0;
    end else if (bit_cnt >= 5'(`SCP_DATA_FIRST) &&
                 bit_cnt < 5'(`SCP_DATA_LAST)) begin
      din <= {din[5:0], bus.sdio};
    end
  end

  always_ff @(posedge bus.sclk) begin
    if (last_write && mapped(addr)) begin
      store[addr[STORE_BITS-1:0]] <= next_wr_byte; // RULE5
    end
  end

  // Written frames are reported to the system side by a toggle.
  always_ff @(posedge bus.sclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_tgl    <= 1'b0;
      wr_addr_l <= '0;
      wr_data_l <= `SCP_BYTE_RESET;
    end else if (last_write) begin
      wr_tgl    <= ~wr_tgl;
      wr_addr_l <= addr;
      wr_data_l <= next_wr_byte;
    end
  end

  // Read data leaves on falling edges so the host samples it settled.
  always_ff @(negedge bus.sclk or negedge rst_n or posedge bus.cs_n) begin
    if (!rst_n) begin
      dout    <= `SCP_BYTE_RESET;
      sdio_oe <= 1'b0;
      sdo_oe  <= 1'b0;
    end else if (bus.cs_n) begin
      sdio_oe <= 1'b0;
      sdo_oe  <= 1'b0;
    end else if (dir == `SCP_DIR_READ &&
                 bit_cnt == 5'(`SCP_DATA_FIRST)) begin
      dout    <= mapped(addr) ? store[addr[STORE_BITS-1:0]]
                              : `SCP_BYTE_RESET; // RULE7
      sdio_oe <= mode_s2; // RULE1
      sdo_oe  <= ~mode_s2; // RULE1
    end else if (bit_cnt == 5'(`SCP_FRAME_BITS)) begin
      sdio_oe <= 1'b0;
      sdo_oe  <= 1'b0;
    end else begin
      dout <= {dout[6:0], 1'b0}; // RULE7
    end
  end

  assign bus.dev_sdio_out       = dout[7];
  assign bus.dev_sdio_oe        = sdio_oe;
  assign bus.serial_data_out    = dout[7];
  assign bus.serial_data_out_oe = sdo_oe;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= wr_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  // The latched words are steady for a whole frame after the toggle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= `SCP_BYTE_RESET;
    end else begin
      wr_valid <= tgl_s2 ^ tgl_s3;
      if (tgl_s2 ^ tgl_s3) begin
        wr_addr <= wr_addr_l;
        wr_data <= wr_data_l;
      end
    end
  end
endmodule

//--- tb/scp_monitor.sv
`timescale 1ns/1ps

module scp_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_oe,
  input wire logic serial_data_out_oe,
  input wire logic sdio,
  input wire logic sdo_line
);
  logic       sclk_d;
  logic [4:0] cnt;

  // Counts serial clock rises inside the frame, seen from the system clock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d <= 1'b0;
      cnt    <= 5'h00;
    end else begin
      sclk_d <= sclk;
      if (cs_n)
        cnt <= 5'h00;
      else if (sclk && !sclk_d)
        cnt <= cnt + 5'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_no_fight: assert property (
    !(host_sdio_oe && dev_sdio_oe)) else $error("shared line driven twice");
  chk_bit_count: assert property (
    $rose(cs_n) |-> cnt == 5'h18) else $error("frame not 24 clocks");
  chk_sclk_high: assert property (
    $rose(sclk) |=> sclk ##1 !sclk) else $error("clock high phase wrong");
  chk_dir_driven: assert property (
    $fell(cs_n) |-> host_sdio_oe && !sclk) else $error("first bit not driven");
  chk_bits_steady: assert property (
    sclk && sclk_d && !cs_n |-> $stable(sdio) && $stable(sdo_line))
    else $error("data moved while clock high");
  chk_host_release: assert property (
    $fell(host_sdio_oe) && !cs_n |-> cnt == 5'h10 || cnt == 5'h18)
    else $error("host released line early");
  chk_dev_late: assert property (
    dev_sdio_oe || serial_data_out_oe |-> cnt >= 5'h10)
    else $error("device drove before byte slot");
  chk_dev_quiet: assert property (
    cs_n |-> !dev_sdio_oe && !serial_data_out_oe)
    else $error("device drove outside frame");
  chk_sclk_idle: assert property (
    cs_n |-> !sclk) else $error("clock moved outside frame");
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps

module tb;
  import scp_pkg::*;
  typedef struct packed {
    logic     tw;
    logic     rd;
    addr_type addr;
    data_type data;
  } row_type;
  logic        clk;
  logic        rst_n;
  logic        three_wire;
  logic        start;
  logic        read;
  addr_type    addr;
  data_type    wdata;
  logic        busy;
  logic        done;
  data_type    rdata;
  logic        wr_valid;
  addr_type    wr_addr;
  data_type    wr_data;
  logic [23:0] fr;
  logic [7:0]  so_fr;
  int          nb;
  int          wr_cnt;
  int          w0;
  int          miscompares;
  int          checks;
  row_type     rows [12];

  scp_if bus ();
  scp_host u_scp_host (.bus(bus), .clk(clk), .rst_n(rst_n),
    .three_wire(three_wire), .start(start), .read(read), .addr(addr),
    .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
  scp_device u_scp_device (.bus(bus), .clk(clk), .rst_n(rst_n),
    .three_wire(three_wire), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data));
  scp_monitor u_scp_monitor (.clk(clk), .rst_n(rst_n), .sclk(bus.sclk),
    .cs_n(bus.cs_n), .host_sdio_oe(bus.host_sdio_oe),
    .dev_sdio_oe(bus.dev_sdio_oe),
    .serial_data_out_oe(bus.serial_data_out_oe), .sdio(bus.sdio),
    .sdo_line(bus.sdo_line));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wr_valid === 1'b1)
      wr_cnt = wr_cnt + 1;
  end

  // Rebuilds each frame as seen on the wires, sampled on serial clock rises.
  always @(negedge bus.cs_n) nb = 0;
  always @(posedge bus.sclk) begin
    if (bus.cs_n === 1'b0) begin
      fr = {fr[22:0], bus.sdio};
      so_fr = {so_fr[6:0], bus.sdo_line};
      nb = nb + 1;
    end
  end

  task automatic bad(input logic [23:0] got, input logic [23:0] exp);
    miscompares++;
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
  endtask

  task automatic chk_frame(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) bad(got, exp);
  endtask

  task automatic chk_byte(input data_type got, input data_type exp);
    checks++;
    if (got !== exp) bad({16'h0000, got}, {16'h0000, exp});
  endtask

  task automatic chk_addr(input addr_type got, input addr_type exp);
    checks++;
    if (got !== exp) bad({9'h000, got}, {9'h000, exp});
  endtask

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic launch(input row_type r);
    @(negedge clk);
    while (busy !== 1'b0) @(negedge clk);
    three_wire = r.tw;
    read = r.rd;
    addr = r.addr;
    wdata = r.data;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask

  task automatic do_row(input row_type r);
    int n;
    w0 = wr_cnt;
    launch(r);
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk_byte({7'h00, done}, 8'h01);
    n = 0;
    while (!r.rd && wr_cnt == w0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk_byte(nb[7:0], 8'h18);
    chk_frame(fr, {r.rd, r.addr, (r.rd && !r.tw) ? 8'hFF : r.data});
    chk_byte(8'(wr_cnt - w0), {7'h00, !r.rd});
    if (r.rd) chk_byte(rdata, r.data);
    if (r.rd && !r.tw) chk_byte(so_fr, r.data);
    if (!r.rd) chk_addr(wr_addr, r.addr);
    if (!r.rd) chk_byte(wr_data, r.data);
    $display("test at %h ended", r.addr);
  endtask

  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    three_wire = 1'b0;
    start = 1'b0;
    read = 1'b0;
    addr = 15'h0000;
    wdata = 8'h00;
    rows = '{'{1'b0, 1'b0, 15'h0012, 8'hA5}, '{1'b0, 1'b0, 15'h00FF, 8'h3C},
             '{1'b0, 1'b1, 15'h0012, 8'hA5}, '{1'b0, 1'b1, 15'h00FF, 8'h3C},
             '{1'b1, 1'b0, 15'h0001, 8'h5A}, '{1'b1, 1'b1, 15'h0001, 8'h5A},
             '{1'b1, 1'b1, 15'h0012, 8'hA5}, '{1'b1, 1'b0, 15'h7FFF, 8'h77},
             '{1'b1, 1'b1, 15'h7FFF, 8'h00}, '{1'b1, 1'b1, 15'h00FF, 8'h3C},
             '{1'b0, 1'b0, 15'h0080, 8'h81}, '{1'b0, 1'b1, 15'h0080, 8'h81}};
    repeat (12) @(negedge clk);
    chk_byte({4'h0, bus.cs_n, bus.sclk, busy, done}, 8'h08);
    rst_n = 1'b1;
    $display("test reset ended");
    foreach (rows[i]) do_row(rows[i]);
    // A write cut short by reset must leave the stored byte untouched.
    launch('{1'b0, 1'b0, 15'h0012, 8'h00});
    repeat (40) @(negedge clk);
    w0 = wr_cnt;
    rst_n = 1'b0;
    @(negedge clk);
    chk_byte({4'h0, bus.cs_n, bus.sclk, busy, done}, 8'h08);
    @(negedge clk);
    chk_byte(8'(wr_cnt - w0), 8'h00);
    rst_n = 1'b1;
    do_row('{1'b0, 1'b1, 15'h0012, 8'hA5});
    $display("test abort ended");
    give_verdict();
  end
endmodule
